// [hw/csm_consts.svh]
// Purpose: Constants for the channel sequence, servo and margin block
// Assumes: Included by bare name
// Notes:   Offsets are command codes of the register port
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH
`define CSM_OFF_TOOL0        8'hB0
`define CSM_OFF_TOOL1_PG     8'hB1
`define CSM_OFF_OEM          8'hB2
`define CSM_OFF_SCR_PG       8'hB3
`define CSM_OFF_SCR_UNPG     8'hB4
`define CSM_OFF_MAKER1       8'hB5
`define CSM_OFF_MAKER2       8'hBC
`define CSM_SCR_RESET        16'h0000
`define CSM_CFG_CONT_BIT     7
`define CSM_CFG_WARN_BIT     6
`define CSM_CFG_SEQOFF_BIT   5
`define CSM_CFG_DAC_LSB      3
`define CSM_CFG_SRC_LSB      0
`define CSM_OP_ON_BIT        7
`define CSM_OP_MARG_LSB      4
`define CSM_SOFT_TOL         16'h0001
`endif

// [hw/csm_pkg.sv]
// Purpose: Types for the channel sequence, servo and margin block
// Assumes: Nothing
// Notes:   Constants live in csm_consts.svh
package csm_pkg;
    typedef enum logic [1:0] {
        SRC_VIN  = 2'b00,
        SRC_CMD  = 2'b01,
        SRC_PIN  = 2'b10,
        SRC_BOTH = 2'b11
    } csm_src_t;
    typedef enum logic [1:0] {
        DAC_SOFT   = 2'b00,
        DAC_OFF    = 2'b01,
        DAC_MSOFT  = 2'b10,
        DAC_MHARD  = 2'b11
    } csm_dac_t;
    typedef enum logic [1:0] {
        MARG_NOM  = 2'b00,
        MARG_LOW  = 2'b01,
        MARG_HIGH = 2'b10,
        MARG_RSV  = 2'b11
    } csm_marg_t;
    typedef enum logic [2:0] {
        CH_OFF     = 3'b000,
        CH_WAIT_ON = 3'b001,
        CH_RISE    = 3'b010,
        CH_ON      = 3'b011,
        CH_WAIT_OF = 3'b100,
        CH_HELD    = 3'b101
    } csm_chst_t;
endpackage : csm_pkg

// [hw/csm_seq_if.sv]
// Purpose: Sequence request bundle from top to each channel
// Assumes: One clock domain
// Notes:   Top drives, channels listen
`timescale 1ns/100ps
`default_nettype none
interface csm_seq_if;
    logic        start_on;
    logic        start_off;
    logic        off_now;
    logic        seq_off;
    logic [15:0] seq_time;
    modport top (output start_on, output start_off, output off_now, output seq_off,
                 output seq_time);
    modport ch  (input start_on, input start_off, input off_now, input seq_off,
                 input seq_time);
endinterface : csm_seq_if
`default_nettype wire

// [hw/csm_channel.sv]
// Purpose: One channel: enable timing, trim servo, margin, discharge hold-off
// Assumes: Measurements arrive with a conversion strobe
// Notes:   Trim steps one code per conversion in soft start and servo; manual modes load dac_sw
`timescale 1ns/100ps
`default_nettype none
`include "csm_consts.svh"
module csm_channel #(
    parameter int W = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    csm_seq_if.ch            seq,
    input  wire logic [7:0]  cfg,
    input  wire logic [1:0]  marg_req,
    input  wire logic [W-1:0] ton_delay,
    input  wire logic [W-1:0] ton_rise,
    input  wire logic [W-1:0] ton_max,
    input  wire logic [W-1:0] toff_delay,
    input  wire logic [W-1:0] vout_cmd,
    input  wire logic [W-1:0] vout_mhi,
    input  wire logic [W-1:0] vout_mlo,
    input  wire logic [W-1:0] ov_fault,
    input  wire logic [W-1:0] ov_warn,
    input  wire logic [W-1:0] uv_warn,
    input  wire logic [W-1:0] uv_fault,
    input  wire logic [7:0]  dis_factor,
    input  wire logic        ov_ignore,
    input  wire logic        uv_off_en,
    input  wire logic [W-1:0] vout_meas,
    input  wire logic [W-1:0] fb_meas,
    input  wire logic        conv_strobe,
    input  wire logic [W-1:0] dac_sw,
    input  wire logic        dac_sw_wr,
    output logic             en_q,
    output logic [W-1:0]     trim_q,
    output logic             trim_oe_q,
    output logic             ov_q,
    output logic             uv_q,
    output logic             held_q
);
    csm_pkg::csm_chst_t st_q;
    csm_pkg::csm_marg_t marg_q;
    csm_pkg::csm_dac_t  mode;
    logic               servo_q;
    logic [W-1:0]       target;
    logic [W+7:0]       thr_prod;
    logic [W-1:0]       off_thr;
    logic [W-1:0]       diff;
    logic               near_fb;

    assign mode     = csm_pkg::csm_dac_t'(cfg[`CSM_CFG_DAC_LSB +: 2]);
    assign thr_prod = vout_cmd * dis_factor;
    // Factor is an unsigned fraction with 8 fractional bits
    assign off_thr  = thr_prod[W+7:8];
    assign target   = (marg_q == csm_pkg::MARG_HIGH) ? vout_mhi :
                      (marg_q == csm_pkg::MARG_LOW)  ? vout_mlo : vout_cmd;
    assign diff     = (trim_q > fb_meas) ? trim_q - fb_meas : fb_meas - trim_q;
    assign near_fb  = diff <= W'(`CSM_SOFT_TOL);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q <= csm_pkg::CH_OFF;
            en_q <= 1'b0;
            uv_q <= 1'b0;
        end else if (seq.off_now) begin
            st_q <= csm_pkg::CH_OFF;
            en_q <= 1'b0;
        end else begin
            unique case (st_q)
                csm_pkg::CH_OFF, csm_pkg::CH_HELD: begin
                    if (seq.start_on) begin
                        // Output must discharge first to avoid a restart on a live rail
                        st_q <= (vout_meas < off_thr) ? csm_pkg::CH_WAIT_ON
                                                       : csm_pkg::CH_HELD;
                        uv_q <= 1'b0;
                    end else if (st_q == csm_pkg::CH_HELD && seq.seq_off) begin
                        // Request gone while held: no late start
                        st_q <= csm_pkg::CH_OFF;
                    end else if (st_q == csm_pkg::CH_HELD && vout_meas < off_thr) begin
                        st_q <= csm_pkg::CH_WAIT_ON;
                    end
                end
                csm_pkg::CH_WAIT_ON: begin
                    if (seq.start_off) st_q <= csm_pkg::CH_WAIT_OF;
                    else if (seq.seq_time >= ton_delay) begin
                        en_q <= 1'b1;
                        st_q <= csm_pkg::CH_RISE;
                    end
                end
                csm_pkg::CH_RISE: begin
                    if (seq.start_off) st_q <= csm_pkg::CH_WAIT_OF;
                    else if (seq.seq_time >= ton_delay + ton_rise) st_q <= csm_pkg::CH_ON;
                end
                csm_pkg::CH_ON: begin
                    if (seq.start_off) st_q <= csm_pkg::CH_WAIT_OF;
                end
                csm_pkg::CH_WAIT_OF: begin
                    if (seq.seq_time >= toff_delay) begin
                        en_q <= 1'b0;
                        st_q <= csm_pkg::CH_OFF;
                    end
                end
                default: st_q <= csm_pkg::CH_OFF;
            endcase
            if (en_q && seq.seq_time == ton_delay + ton_max && vout_meas < uv_fault
                && st_q != csm_pkg::CH_WAIT_OF) begin
                uv_q <= 1'b1;
                if (uv_off_en) begin
                    en_q <= 1'b0;
                    st_q <= csm_pkg::CH_OFF;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) held_q <= 1'b0;
        else held_q <= (st_q == csm_pkg::CH_HELD);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) ov_q <= 1'b0;
        else ov_q <= !(ov_ignore && marg_q != csm_pkg::MARG_NOM) && vout_meas > ov_fault;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) marg_q <= csm_pkg::MARG_NOM;
        else if (st_q != csm_pkg::CH_ON) marg_q <= csm_pkg::MARG_NOM;
        else if (trim_oe_q && marg_req != 2'b11) marg_q <= csm_pkg::csm_marg_t'(marg_req);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trim_q    <= '0;
            trim_oe_q <= 1'b0;
            servo_q   <= 1'b0;
        end else if (st_q != csm_pkg::CH_ON || mode == csm_pkg::DAC_OFF) begin
            trim_oe_q <= 1'b0;
            servo_q   <= 1'b0;
            if (mode == csm_pkg::DAC_MHARD) trim_q <= dac_sw;
        end else if (!trim_oe_q) begin
            if (mode == csm_pkg::DAC_MHARD) trim_oe_q <= 1'b1;
            else if (conv_strobe) begin
                if (near_fb) begin
                    trim_oe_q <= 1'b1;
                    servo_q   <= (mode == csm_pkg::DAC_SOFT);
                end else trim_q <= (trim_q < fb_meas) ? trim_q + 1'b1 : trim_q - 1'b1;
            end
        end else if (mode != csm_pkg::DAC_SOFT) begin
            if (dac_sw_wr) trim_q <= dac_sw;
        end else if (conv_strobe) begin
            // Higher trim code lowers output in this polarity
            if (servo_q || cfg[`CSM_CFG_CONT_BIT]) begin
                if (vout_meas < target) trim_q <= trim_q - 1'b1;
                else if (vout_meas > target) trim_q <= trim_q + 1'b1;
                else if (!cfg[`CSM_CFG_CONT_BIT]) servo_q <= 1'b0;
            end else if (cfg[`CSM_CFG_WARN_BIT] &&
                         (vout_meas > ov_warn || vout_meas < uv_warn)) begin
                servo_q <= 1'b1;
            end
            if (marg_req != 2'b11 && csm_pkg::csm_marg_t'(marg_req) != marg_q) servo_q <= 1'b1;
        end
    end
endmodule : csm_channel
`default_nettype wire

// [hw/csm_top.sv]
// Purpose: Four-channel sequencer, servo and margin control
// Assumes: Register port is a word command port with page select
// Notes:   Scratch storage is flip-flops; persistence is outside
`timescale 1ns/100ps
`default_nettype none
`include "csm_consts.svh"
module csm_top #(
    parameter int NCH = 4,
    parameter int W   = 16
) (
    input  wire logic           clk_sys,
    input  wire logic           rst_n,
    input  wire logic [W-1:0]   input_sense,
    input  wire logic [W-1:0]   vin_on,
    input  wire logic [W-1:0]   vin_off,
    input  wire logic           control_pin,
    input  wire logic [7:0]     operation,
    input  wire logic           operation_wr,
    input  wire logic [1:0]     page,
    input  wire logic [8*NCH-1:0] channel_config_register,
    input  wire logic [7:0]     discharge_threshold_factor,
    input  wire logic [W*NCH-1:0] ton_delay,
    input  wire logic [W*NCH-1:0] ton_rise,
    input  wire logic [W*NCH-1:0] ton_max,
    input  wire logic [W*NCH-1:0] toff_delay,
    input  wire logic [W*NCH-1:0] vout_cmd,
    input  wire logic [W*NCH-1:0] vout_mhi,
    input  wire logic [W*NCH-1:0] vout_mlo,
    input  wire logic [W*NCH-1:0] ov_fault,
    input  wire logic [W*NCH-1:0] ov_warn,
    input  wire logic [W*NCH-1:0] uv_warn,
    input  wire logic [W*NCH-1:0] uv_fault,
    input  wire logic           ov_ignore,
    input  wire logic [NCH-1:0] uv_off_en,
    input  wire logic [W*NCH-1:0] vout_meas,
    input  wire logic [W*NCH-1:0] fb_meas,
    input  wire logic           conv_strobe,
    input  wire logic [W-1:0]   dac_sw,
    input  wire logic           dac_sw_wr,
    input  wire logic [7:0]     reg_addr,
    input  wire logic [W-1:0]   reg_wdata,
    input  wire logic           reg_wr,
    output logic [W-1:0]        reg_rdata,
    output logic                reg_hit,
    input  wire logic           shared_fault_line_n_i,
    output logic                shared_fault_line_n_o,
    output logic                shared_fault_line_n_oe,
    output logic [NCH-1:0]      converter_enable_out,
    output logic [W*NCH-1:0]    trim_output,
    output logic [NCH-1:0]      trim_output_oe,
    output logic [NCH-1:0]      status_held_q,
    output logic [NCH-1:0]      ov_fault_q,
    output logic [NCH-1:0]      uv_fault_q,
    output logic                alert_out_n
);
    logic              vin_ok_q;
    logic              req_on;
    logic              req_on_q;
    logic              cmd_on_q;
    logic [1:0]        marg_cmd_q;
    logic [W-1:0]      seq_time_q;
    logic [W-1:0]      word0_q;
    logic [W-1:0]      oem_q;
    logic [W-1:0]      unpg_q;
    logic [W-1:0]      tool1_q [NCH];
    logic [W-1:0]      scr_q   [NCH];
    logic [W-1:0]      mk1_q   [NCH];
    logic [W-1:0]      mk2_q   [NCH];
    logic [NCH-1:0]    want_on;
    logic [NCH-1:0]    en;
    logic [NCH-1:0]    held;
    logic [NCH-1:0]    sel_dac_wr;
    logic              vin_fall;

    csm_seq_if seq ();

    // Input window gates every other on request
    always_ff @(posedge clk_sys) begin
        if (!rst_n) vin_ok_q <= 1'b0;
        else if (input_sense > vin_on) vin_ok_q <= 1'b1;
        else if (input_sense < vin_off) vin_ok_q <= 1'b0;
    end
    assign vin_fall = vin_ok_q && input_sense < vin_off;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmd_on_q   <= 1'b0;
            marg_cmd_q <= 2'b00;
        end else if (operation_wr && vin_ok_q) begin
            cmd_on_q   <= operation[`CSM_OP_ON_BIT];
            marg_cmd_q <= operation[`CSM_OP_MARG_LSB +: 2];
        end
    end

    // Source selection follows channel 0 config; one shared sequence timer
    always_comb begin
        unique case (csm_pkg::csm_src_t'(channel_config_register[`CSM_CFG_SRC_LSB +: 2]))
            csm_pkg::SRC_VIN:  req_on = 1'b1;
            csm_pkg::SRC_CMD:  req_on = cmd_on_q;
            csm_pkg::SRC_PIN:  req_on = control_pin;
            csm_pkg::SRC_BOTH: req_on = cmd_on_q && control_pin;
        endcase
        req_on = req_on && vin_ok_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) req_on_q <= 1'b0;
        else req_on_q <= req_on;
    end

    assign seq.start_on  = req_on && !req_on_q;
    // Sequenced off on input loss only when configured
    assign seq.start_off = (!req_on && req_on_q && !vin_fall) ||
                           (vin_fall && channel_config_register[`CSM_CFG_SEQOFF_BIT]);
    assign seq.off_now   = vin_fall && !channel_config_register[`CSM_CFG_SEQOFF_BIT];
    assign seq.seq_off   = !req_on;
    assign seq.seq_time  = seq_time_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) seq_time_q <= '0;
        else if (seq.start_on || seq.start_off) seq_time_q <= '0;
        else if (seq_time_q != '1) seq_time_q <= seq_time_q + 1'b1;
    end

    generate
        for (genvar i = 0; i < NCH; i++) begin : g_ch
            assign sel_dac_wr[i] = dac_sw_wr && page == 2'(i);
            csm_channel #(.W(W)) u_ch (
                .clk_sys     (clk_sys),
                .rst_n       (rst_n),
                .seq         (seq),
                .cfg         (channel_config_register[8*i +: 8]),
                .marg_req    (marg_cmd_q),
                .ton_delay   (ton_delay[W*i +: W]),
                .ton_rise    (ton_rise[W*i +: W]),
                .ton_max     (ton_max[W*i +: W]),
                .toff_delay  (toff_delay[W*i +: W]),
                .vout_cmd    (vout_cmd[W*i +: W]),
                .vout_mhi    (vout_mhi[W*i +: W]),
                .vout_mlo    (vout_mlo[W*i +: W]),
                .ov_fault    (ov_fault[W*i +: W]),
                .ov_warn     (ov_warn[W*i +: W]),
                .uv_warn     (uv_warn[W*i +: W]),
                .uv_fault    (uv_fault[W*i +: W]),
                .dis_factor  (discharge_threshold_factor),
                .ov_ignore   (ov_ignore),
                .uv_off_en   (uv_off_en[i]),
                .vout_meas   (vout_meas[W*i +: W]),
                .fb_meas     (fb_meas[W*i +: W]),
                .conv_strobe (conv_strobe),
                .dac_sw      (dac_sw),
                .dac_sw_wr   (sel_dac_wr[i]),
                .en_q        (en[i]),
                .trim_q      (trim_output[W*i +: W]),
                .trim_oe_q   (trim_output_oe[i]),
                .ov_q        (ov_fault_q[i]),
                .uv_q        (uv_fault_q[i]),
                .held_q      (held[i])
            );
        end
    endgenerate

    assign converter_enable_out = en;
    assign status_held_q        = held;
    assign alert_out_n          = !(|held || |ov_fault_q || |uv_fault_q);
    // Open drain fault line: drive low only
    assign shared_fault_line_n_o  = 1'b0;
    assign shared_fault_line_n_oe = |(uv_fault_q & uv_off_en);

    // Scratch and reserved words; storage persistence handled outside
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            word0_q <= `CSM_SCR_RESET;
            oem_q   <= `CSM_SCR_RESET;
            unpg_q  <= `CSM_SCR_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `CSM_OFF_TOOL0) word0_q <= reg_wdata;
            if (reg_addr == `CSM_OFF_OEM) oem_q <= reg_wdata;
            if (reg_addr == `CSM_OFF_SCR_UNPG) unpg_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                tool1_q[i] <= `CSM_SCR_RESET;
                scr_q[i]   <= `CSM_SCR_RESET;
                mk1_q[i]   <= `CSM_SCR_RESET;
                mk2_q[i]   <= `CSM_SCR_RESET;
            end
        end else if (reg_wr) begin
            if (reg_addr == `CSM_OFF_TOOL1_PG) tool1_q[page] <= reg_wdata;
            if (reg_addr == `CSM_OFF_SCR_PG) scr_q[page] <= reg_wdata;
            if (reg_addr == `CSM_OFF_MAKER1) mk1_q[page] <= reg_wdata;
            if (reg_addr == `CSM_OFF_MAKER2) mk2_q[page] <= reg_wdata;
        end
    end

    always_comb begin
        reg_hit   = 1'b1;
        unique case (reg_addr)
            `CSM_OFF_TOOL0:    reg_rdata = word0_q;
            `CSM_OFF_TOOL1_PG: reg_rdata = tool1_q[page];
            `CSM_OFF_OEM:      reg_rdata = oem_q;
            `CSM_OFF_SCR_PG:   reg_rdata = scr_q[page];
            `CSM_OFF_SCR_UNPG: reg_rdata = unpg_q;
            `CSM_OFF_MAKER1:   reg_rdata = mk1_q[page];
            `CSM_OFF_MAKER2:   reg_rdata = mk2_q[page];
            default: begin
                reg_rdata = '0;
                reg_hit   = 1'b0;
            end
        endcase
    end
endmodule : csm_top
`default_nettype wire

// [bench/csm_conv_model.sv]
// Purpose: Converter model: output level and conversion strobe
// Assumes: One conversion every four clocks
// Notes:   Rails start charged, so the first start meets a hold-off
`timescale 1ns/100ps
`default_nettype none
module csm_conv_model #(
    parameter int NCH = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [NCH-1:0]    converter_enable_out,
    output logic      [16*NCH-1:0] vout_meas,
    output logic      [16*NCH-1:0] fb_meas,
    output logic                   conv_strobe
);
    logic [1:0] div_q;
    assign fb_meas = {NCH{16'h0004}};
    always_ff @(posedge clk_sys) begin
        div_q       <= rst_n ? div_q + 2'h1 : 2'h0;
        conv_strobe <= rst_n && div_q == 2'h3;
    end
    // Slow decay; a disabled rail never snaps to zero
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < NCH; i++) begin
            if (!rst_n || converter_enable_out[i]) begin
                vout_meas[16*i +: 16] <= 16'h1000;
            end else if (conv_strobe && vout_meas[16*i +: 16] != 16'h0000) begin
                vout_meas[16*i +: 16] <= vout_meas[16*i +: 16] - 16'h0200;
            end
        end
    end
endmodule : csm_conv_model
`default_nettype wire

// [bench/csm_monitor.sv]
// Purpose: Port assertions for csm_top
// Assumes: Channel 0 pin-sourced for the timing checks
// Notes:   Bound to every csm_top
`timescale 1ns/100ps
`default_nettype none
module csm_monitor #(
    parameter int NCH = 4,
    parameter int W   = 16
) (
    input wire logic             clk_sys,
    input wire logic             rst_n,
    input wire logic [W-1:0]     input_sense,
    input wire logic [W-1:0]     vin_on,
    input wire logic [W-1:0]     vin_off,
    input wire logic             control_pin,
    input wire logic [8*NCH-1:0] channel_config_register,
    input wire logic [W*NCH-1:0] ton_delay,
    input wire logic [W*NCH-1:0] toff_delay,
    input wire logic             dac_sw_wr,
    input wire logic [7:0]       reg_addr,
    input wire logic [W-1:0]     reg_rdata,
    input wire logic             reg_hit,
    input wire logic [NCH-1:0]   converter_enable_out,
    input wire logic [W*NCH-1:0] trim_output,
    input wire logic [NCH-1:0]   trim_output_oe,
    input wire logic [NCH-1:0]   status_held_q,
    input wire logic             alert_out_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [15:0] on_cnt_q;
    logic [15:0] off_cnt_q;
    logic        vin_seen_q;
    // Pin run lengths; wrap is harmless in short runs
    always_ff @(posedge clk_sys) begin
        on_cnt_q  <= (!rst_n || !control_pin) ? 16'h0000 : on_cnt_q + 16'h0001;
        off_cnt_q <= (!rst_n || control_pin) ? 16'h0000 : off_cnt_q + 16'h0001;
    end
    always_ff @(posedge clk_sys) begin
        vin_seen_q <= rst_n && (vin_seen_q || input_sense > vin_on);
    end
    sequence s_vin_low;
        input_sense < vin_off && !channel_config_register[5];
    endsequence
    sequence s_hard_up;
        channel_config_register[20:19] == 2'b11 && trim_output_oe[2] && $past(trim_output_oe[2]);
    endsequence
    a_vin_gate: assert property (|converter_enable_out |-> vin_seen_q)
        else $error("enable before input rose");
    a_vin_loss_off: assert property (s_vin_low ##1 s_vin_low |-> ##[0:3] !(|converter_enable_out))
        else $error("enable kept after input loss");
    a_on_delay: assert property ($rose(converter_enable_out[0]) && channel_config_register[1:0] == 2'b10
        |-> on_cnt_q >= ton_delay[15:0])
        else $error("enable before on delay");
    a_off_delay: assert property ($fell(converter_enable_out[0]) && channel_config_register[1:0] == 2'b10
        && input_sense > vin_off |-> off_cnt_q >= toff_delay[15:0])
        else $error("disable before off delay");
    a_disc_hiz: assert property (channel_config_register[12:11] == 2'b01 |=> !trim_output_oe[1])
        else $error("disconnected trim driven");
    a_hard_hold: assert property (s_hard_up ##0 (!$past(dac_sw_wr) && !$past(dac_sw_wr, 2))
        |-> $stable(trim_output[2*W +: W]))
        else $error("manual trim moved without write");
    a_held_off: assert property ((status_held_q & converter_enable_out) == '0)
        else $error("held channel enabled");
    a_held_alert: assert property (|status_held_q |-> !alert_out_n)
        else $error("alert high while held");
    a_unmapped: assert property (!(reg_addr inside {[8'hB0:8'hB5], 8'hBC})
        |-> !reg_hit && reg_rdata == '0)
        else $error("unmapped address answered");
endmodule : csm_monitor
bind csm_top csm_monitor #(.NCH(NCH), .W(W)) u_mon (.*);
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for csm_top
// Assumes: Converter model drives the measurements
// Notes:   Short delays keep the run brief
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int NCH = 4;
    localparam int W   = 16;
    logic             clk_sys, rst_n, reg_hit, alert_out_n, conv_strobe;
    logic             control_pin = 1'b0, operation_wr = 1'b0, dac_sw_wr = 1'b0, reg_wr = 1'b0;
    logic             ov_ignore = 1'b0, shared_fault_line_n_i = 1'b1;
    logic             shared_fault_line_n_o, shared_fault_line_n_oe;
    logic [W-1:0]     input_sense = 16'h1000, vin_on = 16'h2000, vin_off = 16'h1800;
    logic [W-1:0]     dac_sw = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
    logic [7:0]       operation = 8'h00, reg_addr = 8'hB0, discharge_threshold_factor = 8'h80;
    logic [1:0]       page = 2'h0;
    logic [8*NCH-1:0] channel_config_register = 32'h1018_0882;
    logic [W*NCH-1:0] ton_delay = 64'h0050_003C_0028_0014, toff_delay = 64'h0050_003C_0028_0014;
    logic [W*NCH-1:0] ton_rise = {NCH{16'h0008}}, ton_max = {NCH{16'h0100}};
    logic [W*NCH-1:0] vout_cmd = {NCH{16'h1000}}, vout_mhi = {NCH{16'h1100}};
    logic [W*NCH-1:0] vout_mlo = {NCH{16'h0F00}}, ov_fault = {NCH{16'hFFFF}};
    logic [W*NCH-1:0] ov_warn = {NCH{16'hFFFF}}, uv_warn = {NCH{16'h0000}};
    logic [W*NCH-1:0] uv_fault = {NCH{16'h0000}}, vout_meas, fb_meas, trim_output;
    logic [NCH-1:0]   uv_off_en = 4'h0, converter_enable_out, trim_output_oe;
    logic [NCH-1:0]   status_held_q, ov_fault_q, uv_fault_q;
    int               failures = 0;
    int               cmp_count = 0;
    int               tick = 0;
    csm_top #(.NCH(NCH), .W(W)) u_dut (.*);
    csm_conv_model #(.NCH(NCH)) u_conv (.*);
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [W-1:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr
    // Read data is combinational; sample once it settles
    task automatic rd(input logic [7:0] a, input logic hit, input logic [W-1:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        #1;
        chk({15'h0000, reg_hit}, {15'h0000, hit});
        chk(reg_rdata, exp);
    endtask : rd
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        tick++;
        if (tick == 5000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        rst_n = 1'b0;
        cyc(16);
        rst_n = 1'b1;
        // Start early, while the rails still carry their reset charge
        control_pin = 1'b1;
        cyc(16);
        chk({12'h000, converter_enable_out}, 16'h0000);
        input_sense = 16'h3000;
        cyc(4);
        chk({12'h000, status_held_q}, 16'h000F);
        chk({15'h0000, alert_out_n}, 16'h0000);
        for (int i = 0; i < 400 && converter_enable_out[0] !== 1'b1; i++) cyc(1);
        chk({12'h000, converter_enable_out}, 16'h0001);
        cyc(150);
        chk({12'h000, converter_enable_out}, 16'h000F);
        chk({12'h000, trim_output_oe}, 16'h000D);
        chk({15'h0000, alert_out_n}, 16'h0001);
        page = 2'h2;
        dac_sw = 16'h0123;
        dac_sw_wr = 1'b1;
        cyc(1);
        dac_sw_wr = 1'b0;
        cyc(3);
        chk(trim_output[2*W +: W], 16'h0123);
        page = 2'h1;
        operation = 8'hA0;
        operation_wr = 1'b1;
        cyc(1);
        operation_wr = 1'b0;
        cyc(20);
        chk({12'h000, trim_output_oe}, 16'h000D);
        ov_ignore = 1'b1;
        ov_fault[15:0] = 16'h0F00;
        cyc(2);
        chk({12'h000, ov_fault_q}, 16'h0000);
        ov_ignore = 1'b0;
        cyc(2);
        chk({12'h000, ov_fault_q}, 16'h0001);
        ov_fault[15:0] = 16'hFFFF;
        cyc(2);
        control_pin = 1'b0;
        cyc(30);
        chk({12'h000, converter_enable_out}, 16'h000E);
        cyc(80);
        chk({12'h000, converter_enable_out}, 16'h0000);
        uv_fault[W +: W] = 16'h2000;
        uv_off_en = 4'h2;
        control_pin = 1'b1;
        cyc(300);
        chk({12'h000, converter_enable_out}, 16'h000D);
        chk({12'h000, uv_fault_q}, 16'h0002);
        chk({15'h0000, shared_fault_line_n_oe}, 16'h0001);
        input_sense = 16'h1000;
        cyc(4);
        chk({12'h000, converter_enable_out}, 16'h0000);
        rd(8'hB3, 1'b1, 16'h0000);
        rd(8'hB4, 1'b1, 16'h0000);
        for (int p = 0; p < NCH; p++) begin
            page = p[1:0];
            wr(8'hB3, 16'hA000 + 16'(p));
            wr(8'hB5, 16'hC000 + 16'(p));
        end
        wr(8'hB4, 16'h5A5A);
        for (int p = 0; p < NCH; p++) begin
            page = p[1:0];
            rd(8'hB3, 1'b1, 16'hA000 + 16'(p));
            rd(8'hB5, 1'b1, 16'hC000 + 16'(p));
            rd(8'hB4, 1'b1, 16'h5A5A);
        end
        rd(8'hB6, 1'b0, 16'h0000);
        close_out();
    end
endmodule : tb
`default_nettype wire
